// file: rtl/cis_pkg.sv
package cis_pkg;
	localparam int unsigned CLK_MHZ      = 250;
	localparam int unsigned SEL_DLY_NS   = 1800;
	localparam int unsigned ADR_DLY_NS   = 1000;
	localparam int unsigned STS_HOLD_NS  = 3600;
	localparam int unsigned TAG_DLY_NS   = 1000;
	localparam int unsigned CMD_FALL_NS  = 200;
	// least times, rounded up
	localparam int unsigned SEL_DLY_CYC  = (SEL_DLY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned ADR_DLY_CYC  = (ADR_DLY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned STS_HOLD_CYC = (STS_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TAG_DLY_CYC  = (TAG_DLY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CMD_FALL_CYC = (CMD_FALL_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TMR_W        = 10;
	localparam int unsigned BYTE_W       = 8;
	localparam int unsigned DEV_END_BIT  = 5;
	localparam int unsigned UNIT_CHK_BIT = 6;
	localparam logic [BYTE_W-1:0] STS_KEEP = 8'h40;

	typedef enum logic [2:0] {
		CIS_IDLE   = 3'b000,
		CIS_WSEL   = 3'b001,
		CIS_ADDR   = 3'b011,
		CIS_STAT   = 3'b010,
		CIS_CFALL  = 3'b110,
		CIS_STAG   = 3'b111,
		CIS_WRESP  = 3'b101,
		CIS_WDESEL = 3'b100
	} cis_state_t;
endpackage

// file: rtl/cis_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module cis_sequencer
	import cis_pkg::*;
(
	input  wire logic              clk,             // 250 MHz clock
	input  wire logic              nrst,            // async reset, active low
	input  wire logic [3:0]        cu_addr,         // control unit address
	input  wire logic              addr_par_strap,  // installed address parity bit
	input  wire logic [3:0]        drive_addr,      // selected tape drive address
	input  wire logic [BYTE_W-1:0] status_set,      // pulses setting status latches
	input  wire logic              unit_free,       // selected drive unit free
	input  wire logic              ctl_initial,     // initial status of a control command
	input  wire logic              select_out,      // channel select out
	input  wire logic              command_out,     // channel command out
	input  wire logic              service_out,     // channel service out
	input  wire logic              suppress_out,    // channel suppress out
	output logic                   request_in,      // request in tag
	output logic                   operational_in,  // operational in tag
	output logic                   address_in,      // address in tag
	output logic                   status_in,       // status in tag
	output logic [BYTE_W-1:0]      bus_in,          // bus in data
	output logic                   bus_in_par,      // bus in parity
	output logic                   status_pending,  // blocks new operations
	output logic                   arm_clear,       // pulse: clear selected arm latch
	output logic                   int_stack        // internal stack latch
);
	// ----------------------------------------
	// reset synchroniser
	// ----------------------------------------
	logic rst_s1_r, rst_n_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// ----------------------------------------
	// state and latches
	// ----------------------------------------
	cis_state_t        st_r, st_nxt;
	logic [TMR_W-1:0]  tmr_r, tmr_nxt;
	logic [BYTE_W-1:0] sts_r, sts_nxt;
	logic [BYTE_W-1:0] hold_r, hold_nxt;
	logic              stack_r, stack_nxt;
	logic              istack_r, istack_nxt;
	logic              burst_r, burst_nxt;
	logic              adr_r, adr_nxt;
	logic              stag_r, stag_nxt;
	logic              opin_r, opin_nxt;
	logic              par_r, par_nxt;
	logic              uf_only_r, uf_only_nxt;
	logic              cmd_d_r;

	function automatic logic odd_par(input logic [BYTE_W-1:0] b);
		return ~(^b);
	endfunction

	wire cmd_rise   = command_out & ~cmd_d_r;
	wire uf_any     = unit_free | istack_r;
	wire pend       = (|sts_r) | stack_r;
	wire want_int   = (pend | uf_any) & ~suppress_out;
	wire tmr_done   = (tmr_r == '0);
	wire [BYTE_W-1:0] sts_gate = sts_r |
		(BYTE_W'(unit_free | istack_r) << DEV_END_BIT);

	assign request_in     = (st_r == CIS_IDLE || st_r == CIS_WSEL) && want_int;
	assign operational_in = opin_r;
	assign address_in     = adr_r;
	assign status_in      = stag_r;
	assign bus_in         = hold_r;
	assign bus_in_par     = par_r;
	assign status_pending = pend;
	assign int_stack      = istack_r;
	assign arm_clear      = (st_r == CIS_WRESP) && service_out && unit_free;

	always_comb begin
		st_nxt      = st_r;
		tmr_nxt     = tmr_done ? tmr_r : tmr_r - 1'b1;
		sts_nxt     = sts_r | status_set;
		hold_nxt    = hold_r;
		stack_nxt   = stack_r;
		istack_nxt  = istack_r;
		burst_nxt   = burst_r;
		adr_nxt     = adr_r;
		stag_nxt    = stag_r;
		opin_nxt    = opin_r;
		par_nxt     = par_r;
		uf_only_nxt = uf_only_r;
		unique case (st_r)
			CIS_IDLE: begin
				if (want_int) begin
					st_nxt = CIS_WSEL;
				end
			end
			CIS_WSEL: begin
				if (!want_int && !select_out) begin
					st_nxt = CIS_IDLE;
				end else if (select_out) begin
					st_nxt  = CIS_ADDR;
					tmr_nxt = TMR_W'(SEL_DLY_CYC - 1);
				end
			end
			CIS_ADDR: begin
				if (!adr_r && !burst_r && tmr_done) begin
					stack_nxt   = 1'b0;
					burst_nxt   = 1'b1;
					opin_nxt    = 1'b1;
					hold_nxt    = {cu_addr, drive_addr};
					par_nxt     = addr_par_strap;
					uf_only_nxt = uf_any && (sts_r == '0) && !stack_r;
					tmr_nxt     = TMR_W'(ADR_DLY_CYC - 1);
				end else if (burst_r && !adr_r && tmr_done) begin
					adr_nxt = 1'b1;
				end else if (adr_r && cmd_rise) begin
					hold_nxt = sts_gate;
					par_nxt  = odd_par(sts_gate);
					st_nxt   = CIS_STAT;
					tmr_nxt  = TMR_W'(STS_HOLD_CYC - 1);
				end
			end
			CIS_STAT: begin
				if (tmr_done) begin
					adr_nxt = 1'b0;
					st_nxt  = CIS_CFALL;
				end
			end
			CIS_CFALL: begin
				// wait for command out to fall, then its timing
				if (command_out) begin
					tmr_nxt = TMR_W'(CMD_FALL_CYC - 1);
				end else if (tmr_done) begin
					st_nxt  = CIS_STAG;
					tmr_nxt = TMR_W'(TAG_DLY_CYC - 1);
				end
			end
			CIS_STAG: begin
				if (tmr_done) begin
					stag_nxt = 1'b1;
					st_nxt   = CIS_WRESP;
				end
			end
			CIS_WRESP: begin
				if (service_out) begin
					sts_nxt    = (sts_r & STS_KEEP) | status_set;
					istack_nxt = 1'b0;
					stack_nxt  = 1'b0;
					stag_nxt   = 1'b0;
					burst_nxt  = 1'b0;
					st_nxt     = CIS_WDESEL;
				end else if (cmd_rise) begin
					if (uf_only_r) begin
						istack_nxt = 1'b1;
					end else if (!ctl_initial) begin
						stack_nxt = 1'b1;
					end
					stag_nxt  = 1'b0;
					burst_nxt = 1'b0;
					st_nxt    = CIS_WDESEL;
				end
			end
			CIS_WDESEL: begin
				if (!select_out) begin
					opin_nxt = 1'b0;
					st_nxt   = CIS_IDLE;
				end
			end
			default: st_nxt = CIS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r      <= CIS_IDLE;
			tmr_r     <= '0;
			sts_r     <= '0;
			hold_r    <= '0;
			stack_r   <= 1'b0;
			istack_r  <= 1'b0;
			burst_r   <= 1'b0;
			adr_r     <= 1'b0;
			stag_r    <= 1'b0;
			opin_r    <= 1'b0;
			par_r     <= 1'b0;
			uf_only_r <= 1'b0;
			cmd_d_r   <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			tmr_r     <= tmr_nxt;
			sts_r     <= sts_nxt;
			hold_r    <= hold_nxt;
			stack_r   <= stack_nxt;
			istack_r  <= istack_nxt;
			burst_r   <= burst_nxt;
			adr_r     <= adr_nxt;
			stag_r    <= stag_nxt;
			opin_r    <= opin_nxt;
			par_r     <= par_nxt;
			uf_only_r <= uf_only_nxt;
			cmd_d_r   <= command_out;
		end
	end

	// ----------------------------------------
	// check helpers
	// ----------------------------------------
	// counts status-hold cycles; a long hold is checked on a counter, not unrolled
	logic [TMR_W-1:0] stat_cnt_r;
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			stat_cnt_r <= '0;
		end else if (st_r == CIS_STAT) begin
			stat_cnt_r <= stat_cnt_r + 1'b1;
		end else begin
			stat_cnt_r <= '0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_req_supp;
		@(posedge clk) disable iff (!rst_n_r) suppress_out |-> !request_in;
	endproperty
	a_req_supp: assert property (p_req_supp) else $error("request in under suppress");

	property p_opin_sel;
		@(posedge clk) disable iff (!rst_n_r) $fell(opin_r) |-> !$past(select_out);
	endproperty
	a_opin_sel: assert property (p_opin_sel) else $error("op in dropped with select");

	property p_adr_delay;
		@(posedge clk) disable iff (!rst_n_r) $rose(opin_r) |-> ##250 $rose(adr_r);
	endproperty
	a_adr_delay: assert property (p_adr_delay) else $error("address in delay wrong");

	property p_adr_drop;
		@(posedge clk) disable iff (!rst_n_r) $fell(adr_r)
			|-> (stat_cnt_r == TMR_W'(STS_HOLD_CYC)) && $past(st_r == CIS_STAT);
	endproperty
	a_adr_drop: assert property (p_adr_drop) else $error("address in drop wrong");

	property p_par;
		@(posedge clk) disable iff (!rst_n_r) $rose(stag_r) |-> ^{hold_r, par_r};
	endproperty
	a_par: assert property (p_par) else $error("status parity not odd");

	property p_stack_pend;
		@(posedge clk) disable iff (!rst_n_r) stack_r |-> status_pending;
	endproperty
	a_stack_pend: assert property (p_stack_pend) else $error("stack without pending");

	property p_svc_clear;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_WRESP && service_out)
			|=> !stag_r && !burst_r && ((sts_r & ~STS_KEEP) == $past(status_set & ~STS_KEEP));
	endproperty
	a_svc_clear: assert property (p_svc_clear) else $error("service out clear failed");

	property p_rej;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_WRESP && !service_out && cmd_rise)
			|=> !burst_r && (stack_r || istack_r || $past(ctl_initial));
	endproperty
	a_rej: assert property (p_rej) else $error("rejection not stacked");

	property p_req_pend;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_IDLE && pend && !suppress_out) |-> request_in;
	endproperty
	a_req_pend: assert property (p_req_pend) else $error("pending status without request in");

	property p_burst_opin;
		@(posedge clk) disable iff (!rst_n_r) $rose(burst_r) |-> opin_r && !stack_r;
	endproperty
	a_burst_opin: assert property (p_burst_opin) else $error("forced burst without op in");

	property p_sel_delay;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_WSEL && select_out) |-> ##[451:451] $rose(opin_r);
	endproperty
	a_sel_delay: assert property (p_sel_delay) else $error("op in delay after select wrong");

	property p_addr_byte;
		@(posedge clk) disable iff (!rst_n_r) $rose(opin_r) |-> bus_in == {$past(cu_addr), $past(drive_addr)};
	endproperty
	a_addr_byte: assert property (p_addr_byte) else $error("address byte wrong");

	property p_addr_par;
		@(posedge clk) disable iff (!rst_n_r) $rose(opin_r) |-> bus_in_par == $past(addr_par_strap);
	endproperty
	a_addr_par: assert property (p_addr_par) else $error("address parity not strapped");

	property p_status_byte;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_ADDR && adr_r && cmd_rise)
			|=> bus_in == $past(sts_r | (BYTE_W'(unit_free | istack_r) << DEV_END_BIT));
	endproperty
	a_status_byte: assert property (p_status_byte) else $error("status byte wrong");

	property p_stat_par;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_STAT) |-> ^{bus_in, bus_in_par};
	endproperty
	a_stat_par: assert property (p_stat_par) else $error("status byte parity not odd");

	property p_adr_hold;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_STAT) |-> adr_r && opin_r;
	endproperty
	a_adr_hold: assert property (p_adr_hold) else $error("address in lost during status");

	property p_cfall_tag;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_CFALL) |-> !stag_r;
	endproperty
	a_cfall_tag: assert property (p_cfall_tag) else $error("status in before command out fall");

	property p_stag_delay;
		@(posedge clk) disable iff (!rst_n_r) $rose(st_r == CIS_STAG) |-> ##250 $rose(stag_r);
	endproperty
	a_stag_delay: assert property (p_stag_delay) else $error("status in delay wrong");

	property p_arm;
		@(posedge clk) disable iff (!rst_n_r) arm_clear |-> st_r == CIS_WRESP && service_out;
	endproperty
	a_arm: assert property (p_arm) else $error("arm clear outside acceptance");

	property p_sts_keep;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_WRESP && service_out)
			|=> sts_r[UNIT_CHK_BIT] == ($past(sts_r[UNIT_CHK_BIT]) | $past(status_set[UNIT_CHK_BIT]));
	endproperty
	a_sts_keep: assert property (p_sts_keep) else $error("unit check not kept");

	property p_stag_svc;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_WRESP && service_out) |=> !status_in;
	endproperty
	a_stag_svc: assert property (p_stag_svc) else $error("status in held after service out");

	property p_opin_hold;
		@(posedge clk) disable iff (!rst_n_r) (st_r == CIS_WDESEL && select_out) |=> opin_r;
	endproperty
	a_opin_hold: assert property (p_opin_hold) else $error("op in dropped under select");

	property p_stack_set;
		@(posedge clk) disable iff (!rst_n_r)
			(st_r == CIS_WRESP && !service_out && cmd_rise && !uf_only_r && !ctl_initial) |=> stack_r;
	endproperty
	a_stack_set: assert property (p_stack_set) else $error("refused status not stacked");

	property p_istack_pend;
		@(posedge clk) disable iff (!rst_n_r) (istack_r && !stack_r && sts_r == '0) |-> !status_pending;
	endproperty
	a_istack_pend: assert property (p_istack_pend) else $error("internal stack raised pending");

	property p_retry;
		@(posedge clk) disable iff (!rst_n_r) (stack_r && st_r == CIS_IDLE && !suppress_out) |-> request_in;
	endproperty
	a_retry: assert property (p_retry) else $error("stacked status not retried");
endmodule
`default_nettype wire

// file: tb/cis_channel_model.sv
`timescale 1ns/1ps
`default_nettype none
module cis_channel_model (
	input  wire logic clk,         // bench clock
	input  wire logic go,          // allow a new selection
	input  wire logic reject,      // refuse the status byte
	input  wire logic request_in,  // device request tag
	input  wire logic address_in,  // device address tag
	input  wire logic status_in,   // device status tag
	output logic      select_out,  // select tag
	output logic      command_out, // command tag
	output logic      service_out  // service tag
);
	int st;
	initial begin
		st = 0;
		select_out = 1'b0;
		command_out = 1'b0;
		service_out = 1'b0;
	end
	// sequencing per channel side; answers held until the device tag moves
	always @(posedge clk) begin
		case (st)
			0: if (request_in && go) begin
				select_out <= 1'b1;
				st <= 1;
			end
			1: if (address_in) begin
				command_out <= 1'b1;
				st <= 2;
			end
			2: if (!address_in) begin
				command_out <= 1'b0;
				st <= 3;
			end
			3: if (status_in) begin
				command_out <= reject;
				service_out <= !reject;
				st <= 4;
			end
			default: if (!status_in) begin
				command_out <= 1'b0;
				service_out <= 1'b0;
				select_out <= 1'b0;
				st <= 0;
			end
		endcase
	end
endmodule
`default_nettype wire

// file: tb/cis_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cis_sequencer_tb_top;
	import cis_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, strap = 1'b0, uf = 1'b0, ctl = 1'b0, sup = 1'b0, go = 1'b0, rej = 1'b0;
	logic [3:0] cu = 4'h0, drv = 4'h0;
	logic [7:0] sset = 8'h00, bi;
	logic [15:0] rnd = 16'd25541;
	logic sel, cmd, svc, req, opi, adi, sti, bp, pend, armc, istk;
	int fail_count = 0, n_tests = 0, sts_m = 0, n;
	always #2 clk = ~clk;
	cis_sequencer uut (.clk(clk), .nrst(nrst), .cu_addr(cu), .addr_par_strap(strap), .drive_addr(drv),
		.status_set(sset), .unit_free(uf), .ctl_initial(ctl), .select_out(sel), .command_out(cmd),
		.service_out(svc), .suppress_out(sup), .request_in(req), .operational_in(opi), .address_in(adi),
		.status_in(sti), .bus_in(bi), .bus_in_par(bp), .status_pending(pend), .arm_clear(armc),
		.int_stack(istk));
	cis_channel_model chan (.clk(clk), .go(go), .reject(rej), .request_in(req), .address_in(adi),
		.status_in(sti), .select_out(sel), .command_out(cmd), .service_out(svc));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic sig(input int k);
		case (k)
			0: return sel;
			1: return opi;
			2: return adi;
			default: return sti;
		endcase
	endfunction
	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_for(input int k, input logic v, output int cnt);
		cnt = 0;
		while (sig(k) !== v) begin
			@(posedge clk);
			#1;
			cnt++;
			if (cnt > 3000) begin
				chk(16'hDEAD, 16'h0000);
				close_out();
			end
		end
	endtask
	// one request-in interrupt; expectations from the bench's status model
	task automatic run_seq(input logic r, input logic [7:0] exp_sts);
		logic [7:0] adr;
		logic arm_seen;
		rnd = lfsr(rnd);
		adr = rnd[7:0];
		@(posedge clk);
		cu <= adr[7:4];
		drv <= adr[3:0];
		strap <= rnd[8];
		rej <= r;
		#1;
		chk(req, 1'b1);
		@(posedge clk) go <= 1'b1;
		wait_for(0, 1'b1, n);
		go <= 1'b0;
		wait_for(1, 1'b1, n);
		chk(n >= SEL_DLY_CYC && n <= SEL_DLY_CYC + 2, 1'b1);
		chk({bi, bp}, {adr, strap});
		wait_for(2, 1'b1, n);
		chk(n >= ADR_DLY_CYC && n <= ADR_DLY_CYC + 2, 1'b1);
		wait_for(2, 1'b0, n);
		chk(n >= STS_HOLD_CYC && n <= STS_HOLD_CYC + 4, 1'b1);
		chk({bi, bp}, {exp_sts, ~^exp_sts});
		wait_for(3, 1'b1, n);
		chk(n >= CMD_FALL_CYC + TAG_DLY_CYC && n <= CMD_FALL_CYC + TAG_DLY_CYC + 3, 1'b1);
		arm_seen = 1'b0;
		for (int i = 0; i < 4 && sti === 1'b1; i++) begin
			@(posedge clk);
			#1;
			arm_seen |= (armc === 1'b1);
		end
		chk(sti, 1'b0);
		chk(arm_seen, !r && uf);
		wait_for(1, 1'b0, n);
		chk(sel, 1'b0);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk({opi, adi, sti, req, pend}, 5'h00);
		@(posedge clk) sset <= 8'h20;
		@(posedge clk) sset <= 8'h00;
		sts_m = 8'h20;
		run_seq(1'b0, sts_m[7:0]);
		sts_m &= STS_KEEP;
		chk(pend, 1'b0);
		@(posedge clk) uf <= 1'b1;
		run_seq(1'b1, 8'h20);
		chk({istk, pend}, 2'b10);
		run_seq(1'b0, 8'h20);
		uf <= 1'b0;
		rnd = lfsr(rnd);
		@(posedge clk) sset <= rnd[7:0] | 8'h60;
		@(posedge clk) sset <= 8'h00;
		sts_m |= rnd[7:0] | 8'h60;
		sup <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(req, 1'b0);
		sup <= 1'b0;
		run_seq(1'b1, sts_m[7:0]);
		chk(pend, 1'b1);
		@(posedge clk) sup <= 1'b1;
		@(posedge clk);
		#1;
		chk(req, 1'b0);
		sup <= 1'b0;
		run_seq(1'b0, sts_m[7:0]);
		sts_m &= STS_KEEP;
		chk(pend, sts_m != 0);
		close_out();
	end
endmodule
`default_nettype wire
